// File: rdhi_pkg.sv
package rdhi_pkg;

  // location numbers, as seen by either processor family
  localparam logic [2:0] LOC_DOT = 3'h0;
  localparam logic [2:0] LOC_W_HCOORD = 3'h2;
  localparam logic [2:0] LOC_W_VCOORD = 3'h4;
  localparam logic [2:0] LOC_W_SCROLL = 3'h6;
  localparam logic [2:0] LOC_B_SCROLL = 3'h2;
  localparam logic [2:0] LOC_B_H_HIGH = 3'h4;
  localparam logic [2:0] LOC_B_H_LOW = 3'h5;
  localparam logic [2:0] LOC_B_V_HIGH = 3'h6;
  localparam logic [2:0] LOC_B_V_LOW = 3'h7;

  localparam int ADDR_W = 16;
  localparam int BASE_W = 13;
  localparam int DATA_W = 16;
  localparam int HCOORD_W = 10;
  localparam int VCOORD_W = 9;
  localparam int MEM_AW = HCOORD_W + VCOORD_W;

  // top data bit that turns a dot write into a whole-memory fill
  localparam int FILL_BIT_WORD = 15;
  localparam int FILL_BIT_BYTE = 7;

  // status bit positions
  localparam int W_PEN_BIT = 5;
  localparam int W_VBLANK_BIT = 6;
  localparam int W_READY_BIT = 7;
  localparam int B_READY_BIT = 0;
  localparam int B_VBLANK_BIT = 1;
  localparam int B_PEN_BIT = 2;

  localparam logic [HCOORD_W-1:0] HCOORD_RST = 10'h000;
  localparam logic [VCOORD_W-1:0] VCOORD_RST = 9'h000;
  localparam logic [VCOORD_W-1:0] SCROLL_RST = 9'h000;
  localparam logic [MEM_AW-1:0] MEM_LAST = 19'h7_FFFF;

  // timing: longest times round down to cycles
  localparam int CLK_PERIOD_NS = 10;
  localparam int DOT_WRITE_MAX_NS = 1400;
  localparam int DOT_WRITE_MAX_CYC = DOT_WRITE_MAX_NS / CLK_PERIOD_NS;
  localparam int ERASE_MAX_MS = 48;
  localparam int ERASE_MAX_CYC = (ERASE_MAX_MS * 1000000) / CLK_PERIOD_NS;

  // lines x points
  typedef enum logic [1:0] {
    RES_256X256,
    RES_256X512,
    RES_512X512,
    RES_256X1024
  } rdhi_res_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [MEM_AW-1:0] addr;
    logic wbit;
  } rdhi_mem_req_t;

endpackage

// File: rdhi_top.sv
// Contract
// - horizontal coordinate register holds ten bits, 1024 points
// - vertical coordinate register holds nine bits, 512 lines
// - 512-point mode drops horizontal bit 0; 256-point mode drops two bits
// - vertical coordinate truncated likewise from nine bits in coarser line modes
// - word bus: horizontal at location 2, vertical at location 4
// - byte bus: upper eight coordinate bits at locations 4 and 6
// - byte bus: low coordinate bits at location 5 and 7
// - 256x256 mode: low-byte locations do not change the selected dot
// - coordinate registers are write-only; reads of them return zero
// - host loads coordinates, then writes location 0 to store the dot
// - one image bit per card, taken from a configured data bit
// - single-card system takes the image bit from data bit zero
// - dot write completes within 1.4 microseconds
// - one erase command clears all image memory within 48 ms
// - scroll register shifts the picture vertically by whole lines
// - word bus decodes as memory; byte bus decodes as I/O ports
// - word bus uses even locations only; address bit zero picks byte
// - register group base address is set by jumpers
// - reading location 0 returns the addressed dot
// - top data bit set on a dot write fills memory with the data bit
// - ready flag reads 0 while erasing, 1 when idle; status reads are not taken during the fill, only the READY output goes 0
// - scroll register write-only; its location reads back status flags
`timescale 1ns/1ps
`default_nettype none

module rdhi_top #(
  parameter logic [rdhi_pkg::MEM_AW-1:0] ERASE_LAST = rdhi_pkg::MEM_LAST
) (
  input wire logic CLOCK,
  input wire logic SYS_RST,
  input wire logic BYTE_BUS,
  input wire logic [rdhi_pkg::BASE_W-1:0] BASE_SEL,
  input wire logic STACKED,
  input wire logic [3:0] BIT_SEL,
  input wire logic [1:0] RES_MODE,
  input wire logic [rdhi_pkg::ADDR_W-1:0] BUS_ADDR,
  input wire logic BUS_IO,
  input wire logic BUS_WR,
  input wire logic BUS_RD,
  input wire logic [rdhi_pkg::DATA_W-1:0] BUS_WDATA,
  output logic [rdhi_pkg::DATA_W-1:0] BUS_RDATA,
  output logic BUS_RVALID,
  output rdhi_pkg::rdhi_mem_req_t MEM_REQ,
  input wire logic MEM_RBIT,
  output logic [rdhi_pkg::VCOORD_W-1:0] SCROLL_LINE,
  output logic READY,
  input wire logic VBLANK,
  input wire logic LIGHT_PEN
);

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_RD_MEM,
    ST_RD_DATA,
    ST_ERASE
  } rdhi_state_t;

  rdhi_state_t state_q;
  logic [rdhi_pkg::HCOORD_W-1:0] hcoord_q;
  logic [rdhi_pkg::VCOORD_W-1:0] vcoord_q;
  logic [rdhi_pkg::VCOORD_W-1:0] scroll_q;
  logic [rdhi_pkg::MEM_AW-1:0] erase_addr_q;
  logic erase_val_q;
  logic [3:0] rd_bit_q;
  rdhi_pkg::rdhi_res_t res;
  logic hit;
  logic [2:0] loc;
  logic wr_take;
  logic rd_take;
  logic [3:0] img_bit;
  logic data_bit;
  logic fill_req;
  logic [rdhi_pkg::HCOORD_W-1:0] h_eff;
  logic [rdhi_pkg::VCOORD_W-1:0] v_eff;
  logic [rdhi_pkg::DATA_W-1:0] status_word;
  logic [rdhi_pkg::DATA_W-1:0] rdata_d;

  assign res = rdhi_pkg::rdhi_res_t'(RES_MODE);

  // word bus is memory mapped, byte bus sits in I/O space
  // base compare on jumper straps
  assign hit = (BUS_IO == BYTE_BUS)
    && (BUS_ADDR[rdhi_pkg::ADDR_W-1:3] == BASE_SEL);

  // word bus: address bit zero is the byte select, ignored here
  assign loc = BYTE_BUS ? BUS_ADDR[2:0] : {BUS_ADDR[2:1], 1'b0};

  // nothing is taken during a fill; host is expected to poll ready
  assign wr_take = BUS_WR && hit && (state_q == ST_IDLE);
  assign rd_take = BUS_RD && hit && (state_q == ST_IDLE);

  // one image bit per card, default bit zero when not stacked
  assign img_bit = STACKED ? (BYTE_BUS ? {1'b0, BIT_SEL[2:0]} : BIT_SEL) : 4'h0;
  assign data_bit = BUS_WDATA[img_bit];

  assign fill_req = BYTE_BUS ? BUS_WDATA[rdhi_pkg::FILL_BIT_BYTE]
    : BUS_WDATA[rdhi_pkg::FILL_BIT_WORD];

  // coarse modes drop low coordinate bits
  always_comb begin
    h_eff = hcoord_q;
    v_eff = vcoord_q;
    case (res)
      rdhi_pkg::RES_256X256: begin
        h_eff[1:0] = 2'h0;
        v_eff[0] = 1'b0;
      end
      rdhi_pkg::RES_256X512: begin
        h_eff[0] = 1'b0;
        v_eff[0] = 1'b0;
      end
      rdhi_pkg::RES_512X512: begin
        h_eff[0] = 1'b0;
      end
      rdhi_pkg::RES_256X1024: begin
        v_eff[0] = 1'b0;
      end
      default: begin
        h_eff = hcoord_q;
        v_eff = vcoord_q;
      end
    endcase
  end

  // coordinate registers, held until reloaded
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      hcoord_q <= rdhi_pkg::HCOORD_RST;
      vcoord_q <= rdhi_pkg::VCOORD_RST;
    end else if (wr_take) begin
      if (!BYTE_BUS) begin
        if (loc == rdhi_pkg::LOC_W_HCOORD) begin
          hcoord_q <= BUS_WDATA[rdhi_pkg::HCOORD_W-1:0];
        end
        if (loc == rdhi_pkg::LOC_W_VCOORD) begin
          vcoord_q <= BUS_WDATA[rdhi_pkg::VCOORD_W-1:0];
        end
      end else begin
        case (loc)
          rdhi_pkg::LOC_B_H_HIGH: hcoord_q[9:2] <= BUS_WDATA[7:0];
          rdhi_pkg::LOC_B_V_HIGH: vcoord_q[8:1] <= BUS_WDATA[7:0];
          // low bits stored but masked off in 256x256
          rdhi_pkg::LOC_B_H_LOW: hcoord_q[1:0] <= BUS_WDATA[1:0];
          rdhi_pkg::LOC_B_V_LOW: vcoord_q[0] <= BUS_WDATA[0];
          default: hcoord_q <= hcoord_q;
        endcase
      end
    end
  end

  // scroll register, one line per step
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      scroll_q <= rdhi_pkg::SCROLL_RST;
    end else if (wr_take) begin
      if (!BYTE_BUS && loc == rdhi_pkg::LOC_W_SCROLL) begin
        scroll_q <= BUS_WDATA[rdhi_pkg::VCOORD_W-1:0];
      end else if (BYTE_BUS && loc == rdhi_pkg::LOC_B_SCROLL) begin
        scroll_q <= {1'b0, BUS_WDATA[7:0]};
      end
    end
  end

  assign SCROLL_LINE = scroll_q;

  // control sequencer
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (wr_take && loc == rdhi_pkg::LOC_DOT && fill_req) begin
            state_q <= ST_ERASE;
          end else if (rd_take && loc == rdhi_pkg::LOC_DOT) begin
            state_q <= ST_RD_MEM;
          end
        end
        ST_RD_MEM: state_q <= ST_RD_DATA;
        ST_RD_DATA: state_q <= ST_IDLE;
        ST_ERASE: begin
          if (erase_addr_q == ERASE_LAST) begin
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // fill walk, one word per clock; full sweep is well inside the limit
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      erase_addr_q <= '0;
      erase_val_q <= 1'b0;
    end else if (state_q == ST_IDLE) begin
      erase_addr_q <= '0;
      if (wr_take && loc == rdhi_pkg::LOC_DOT && fill_req) begin
        erase_val_q <= data_bit;
      end
    end else if (state_q == ST_ERASE) begin
      erase_addr_q <= erase_addr_q + 1'b1;
    end
  end

  // memory request: dot write issued the cycle after the access
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      MEM_REQ <= '0;
    end else if (state_q == ST_ERASE) begin
      MEM_REQ.wr <= 1'b1;
      MEM_REQ.rd <= 1'b0;
      MEM_REQ.addr <= erase_addr_q;
      MEM_REQ.wbit <= erase_val_q;
    end else begin
      MEM_REQ.wr <= wr_take && loc == rdhi_pkg::LOC_DOT && !fill_req;
      MEM_REQ.rd <= rd_take && loc == rdhi_pkg::LOC_DOT;
      MEM_REQ.addr <= {v_eff, h_eff};
      MEM_REQ.wbit <= data_bit;
    end
  end

  // ready is low during the fill and rises with the last fill write
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      READY <= 1'b1;
    end else begin
      READY <= !(state_q == ST_ERASE && erase_addr_q != ERASE_LAST)
        && !(state_q == ST_IDLE && wr_take && loc == rdhi_pkg::LOC_DOT && fill_req);
    end
  end

  always_comb begin
    status_word = '0;
    if (BYTE_BUS) begin
      status_word[rdhi_pkg::B_READY_BIT] = READY;
      status_word[rdhi_pkg::B_VBLANK_BIT] = VBLANK;
      status_word[rdhi_pkg::B_PEN_BIT] = LIGHT_PEN;
    end else begin
      status_word[rdhi_pkg::W_READY_BIT] = READY;
      status_word[rdhi_pkg::W_VBLANK_BIT] = VBLANK;
      status_word[rdhi_pkg::W_PEN_BIT] = LIGHT_PEN;
    end
  end

  // coordinate locations read as zero scroll location reads flags
  always_comb begin
    rdata_d = '0;
    if (BYTE_BUS ? (loc == rdhi_pkg::LOC_B_SCROLL) : (loc == rdhi_pkg::LOC_W_SCROLL)) begin
      rdata_d = status_word;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      rd_bit_q <= 4'h0;
    end else if (rd_take) begin
      rd_bit_q <= img_bit;
    end
  end

  // non-dot reads answer next cycle; dot reads wait for the memory bit
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      BUS_RDATA <= '0;
      BUS_RVALID <= 1'b0;
    end else if (state_q == ST_RD_DATA) begin
      BUS_RDATA <= '0;
      BUS_RDATA[rd_bit_q] <= MEM_RBIT;
      BUS_RVALID <= 1'b1;
    end else if (rd_take && loc != rdhi_pkg::LOC_DOT) begin
      BUS_RDATA <= rdata_d;
      BUS_RVALID <= 1'b1;
    end else begin
      BUS_RVALID <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// File: rdhi_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module rdhi_mem_model (
  input wire logic clk,
  input wire rdhi_pkg::rdhi_mem_req_t req,
  output logic rbit
);
  logic mem [0:(1<<rdhi_pkg::MEM_AW)-1];
  always_ff @(posedge clk) begin
    if (req.wr) mem[req.addr] <= req.wbit;
    // toggles outside reads so a stale bit is never mistaken for data
    rbit <= req.rd ? mem[req.addr] : ~rbit;
  end
endmodule
`default_nettype wire

// File: rdhi_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module rdhi_assertions #(
  parameter logic [rdhi_pkg::MEM_AW-1:0] ERASE_LAST = rdhi_pkg::MEM_LAST
) (
  input wire logic CLOCK,
  input wire logic SYS_RST,
  input wire logic BYTE_BUS,
  input wire logic [rdhi_pkg::BASE_W-1:0] BASE_SEL,
  input wire logic [rdhi_pkg::ADDR_W-1:0] BUS_ADDR,
  input wire logic BUS_IO,
  input wire logic BUS_WR,
  input wire logic BUS_RD,
  input wire logic [rdhi_pkg::DATA_W-1:0] BUS_WDATA,
  input wire logic [rdhi_pkg::DATA_W-1:0] BUS_RDATA,
  input wire logic BUS_RVALID,
  input wire rdhi_pkg::rdhi_mem_req_t MEM_REQ,
  input wire logic READY
);
  logic [2:0] loc, flg;
  logic hit, fill, wok, rok, ready_q, rd_q;
  logic [rdhi_pkg::MEM_AW:0] busy_q;
  assign loc = BYTE_BUS ? BUS_ADDR[2:0] : {BUS_ADDR[2:1], 1'b0};
  assign flg = BYTE_BUS ? 3'h2 : 3'h6;
  assign hit = BUS_IO == BYTE_BUS && BUS_ADDR[15:3] == BASE_SEL;
  assign fill = BYTE_BUS ? BUS_WDATA[7] : BUS_WDATA[15];
  // the cycle ready returns still belongs to the fill; a pending dot read refuses writes too
  assign wok = hit && READY && ready_q && !MEM_REQ.rd && !rd_q;
  assign rok = wok && !MEM_REQ.rd && !rd_q;
  always_ff @(posedge CLOCK) begin
    ready_q <= SYS_RST | READY;
    rd_q <= !SYS_RST && MEM_REQ.rd;
    busy_q <= (SYS_RST || READY) ? '0 : busy_q + 1'b1;
  end
  default clocking @(posedge CLOCK); endclocking
  default disable iff (SYS_RST);
  a_dot_write: assert property (wok && BUS_WR && loc == 3'h0 && !fill
    |=> MEM_REQ.wr && READY ##1 (!MEM_REQ.wr || $past(wok && BUS_WR && loc == 3'h0)))
    else $error("dot write not issued");
  a_fill_start: assert property (wok && BUS_WR && loc == 3'h0 && fill
    |=> !READY ##1 MEM_REQ.wr && MEM_REQ.addr == '0) else $error("fill did not start");
  a_fill_step: assert property (!READY && MEM_REQ.wr
    |=> MEM_REQ.wr && MEM_REQ.addr == $past(MEM_REQ.addr) + 1'b1) else $error("fill skipped");
  a_fill_end: assert property ($rose(READY)
    |-> MEM_REQ.wr && MEM_REQ.addr == ERASE_LAST ##1 !MEM_REQ.wr) else $error("fill end");
  a_fill_bound: assert property (busy_q <= ERASE_LAST + 1'b1)
    else $error("fill too long");
  a_dot_read: assert property (rok && BUS_RD && loc == 3'h0
    |=> MEM_REQ.rd ##1 !BUS_RVALID ##1 BUS_RVALID) else $error("dot read timing");
  a_wo_read: assert property (rok && BUS_RD && loc != 3'h0 && loc != flg
    |=> BUS_RVALID && BUS_RDATA == '0) else $error("write-only read not zero");
  a_flags_read: assert property (rok && BUS_RD && loc == flg
    |=> BUS_RVALID && BUS_RDATA[BYTE_BUS ? 0 : 7]) else $error("flags read wrong");
  a_miss_quiet: assert property (BUS_RD && !hit && !MEM_REQ.rd && !rd_q
    |=> !BUS_RVALID) else $error("answered a miss");
  c_fill: cover property ($rose(READY));
  c_dot_read: cover property (MEM_REQ.rd);
  c_flags: cover property (rok && BUS_RD && loc == flg);
endmodule
bind rdhi_top rdhi_assertions #(.ERASE_LAST(ERASE_LAST)) u_chk (.CLOCK, .SYS_RST, .BYTE_BUS,
  .BASE_SEL, .BUS_ADDR, .BUS_IO, .BUS_WR, .BUS_RD, .BUS_WDATA, .BUS_RDATA, .BUS_RVALID,
  .MEM_REQ, .READY);
`default_nettype wire

// File: tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam logic [18:0] EXP [4] = '{19'h7_FBFC, 19'h7_FBFE, 19'h7_FFFE, 19'h7_FBFF};
  logic clk = 1'b0, rst = 1'b1, byte_bus = 1'b0, io = 1'b0, stacked = 1'b0;
  logic wr = 1'b0, rd = 1'b0, vblank = 1'b1, pen = 1'b0, rvalid, mbit, ready;
  logic [12:0] base_sel = 13'h1_5A3;
  logic [3:0] bit_sel = 4'h3;
  logic [1:0] res_mode = 2'h2;
  logic [15:0] addr = 16'h0000, wdata = 16'h0000, rdata, got;
  logic [8:0] scroll;
  rdhi_pkg::rdhi_mem_req_t mreq;
  int failures = 0, total_checks = 0;
  always #5 clk = ~clk;
  rdhi_top #(.ERASE_LAST(19'h0_000F)) u_dut (.CLOCK(clk), .SYS_RST(rst), .BYTE_BUS(byte_bus),
    .BASE_SEL(base_sel), .STACKED(stacked), .BIT_SEL(bit_sel), .RES_MODE(res_mode),
    .BUS_ADDR(addr), .BUS_IO(io), .BUS_WR(wr), .BUS_RD(rd), .BUS_WDATA(wdata),
    .BUS_RDATA(rdata), .BUS_RVALID(rvalid), .MEM_REQ(mreq), .MEM_RBIT(mbit),
    .SCROLL_LINE(scroll), .READY(ready), .VBLANK(vblank), .LIGHT_PEN(pen));
  rdhi_mem_model u_mem (.clk(clk), .req(mreq), .rbit(mbit));
  task automatic test_done();
    if (failures == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [18:0] g, input logic [18:0] e);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic reset_dut();
    rst = 1'b1;
    repeat (3) @(negedge clk);
    rst = 1'b0;
  endtask
  task automatic put(input logic [2:0] l, input logic [15:0] d);
    @(negedge clk);
    addr = {base_sel, l};
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask
  // a read of location 0 answers two cycles later than the others
  task automatic get(input logic [2:0] l, input logic want, output logic [15:0] v);
    @(negedge clk);
    addr = {base_sel, l};
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    for (int n = 0; n < 4 && rvalid !== 1'b1; n++) @(negedge clk);
    v = rdata;
    chk(rvalid, want);
    if (want && rvalid !== 1'b1) test_done();
  endtask
  task automatic t_modes();
    put(3'h2, 16'h03FF);
    put(3'h4, 16'h01FF);
    for (int m = 0; m < 4; m++) begin
      res_mode = 2'(m);
      put(3'h0, 16'h0001);
      chk(mreq.addr, EXP[m]);
      chk(mreq.wbit, 1'b1);
    end
  endtask
  task automatic t_word();
    get(3'h0, 1'b1, got);
    chk(got, 16'h0001);
    get(3'h2, 1'b1, got);
    chk(got, 16'h0000);
    get(3'h7, 1'b1, got);
    chk(got, 16'h00C0);
    put(3'h6, 16'h0123);
    chk(scroll, 9'h123);
    put(3'h0, 16'h0000);
    get(3'h0, 1'b1, got);
    chk(got, 16'h0000);
  endtask
  task automatic t_byte();
    byte_bus = 1'b1;
    io = 1'b1;
    stacked = 1'b1;
    base_sel = 13'h0_0A1;
    reset_dut();
    put(3'h4, 16'h00A5);
    put(3'h5, 16'h0002);
    put(3'h6, 16'h003C);
    put(3'h7, 16'h0001);
    put(3'h2, 16'h00C3);
    chk(scroll, 9'h0C3);
    put(3'h0, 16'h0008);
    chk(mreq.addr, 19'h1_E296);
    chk(mreq.wbit, 1'b1);
    get(3'h0, 1'b1, got);
    chk(got, 16'h0008);
    res_mode = 2'h0;
    put(3'h5, 16'h0003);
    put(3'h0, 16'h0001);
    chk(mreq.addr, 19'h1_E294);
    chk(mreq.wbit, 1'b0);
    pen = 1'b1;
    get(3'h2, 1'b1, got);
    chk(got, 16'h0007);
    pen = 1'b0;
    io = 1'b0;
    get(3'h2, 1'b0, got);
    byte_bus = 1'b0;
    stacked = 1'b0;
    reset_dut();
  endtask
  task automatic t_fill();
    put(3'h0, 16'h8001);
    chk(ready, 1'b0);
    get(3'h6, 1'b0, got);
    for (int n = 0; n < 40 && ready !== 1'b1; n++) @(negedge clk);
    chk(ready, 1'b1);
    if (ready !== 1'b1) test_done();
    // last fill word lands one edge after ready returns
    @(negedge clk);
    for (int i = 0; i < 16; i++) chk(u_mem.mem[i], 1'b1);
  endtask
  initial begin
    reset_dut();
    t_modes();
    t_word();
    t_byte();
    t_fill();
    test_done();
  end
endmodule
`default_nettype wire
